// *** design/pgp_port.v ***
// Seven-pin general-purpose port with alternative-function multiplexing
// ----------------------------------------------------------------------------
// Functional notes
// - Seven pins, each general-purpose or one of its alternative functions.
// - Pin 0 alternatives: power-down in, peripheral request b in, regulator enable a out.
// - Pin 1 alternatives: reset in, warm reset in, bus voltage sense, request a in.
// - Pin 2 alternatives: second serial data (bidirectional) and request b in.
// - Pin 3 alternatives: regulator enable a out and switcher sync in.
// - Pin 4 alternatives: regulator enable b out and second serial clock/select.
// - Pin 5 alternatives: power hold in and regulator enable c out.
// - Pin 6 alternatives: sleep request in, supplies valid out, regulator enable c.
// - Rising, falling or both edges raise per-line maskable interrupts.
// - No pin interrupt while its alternative function is selected.
// - Any general-purpose pin event can serve as a wake-up.
// - Pins 2 and 4 never request switch-on while in OFF mode.
// - Regulator enable outputs follow the power-up sequence step.
// - Two pad selection registers choose general-purpose or alternative per pin.
// - Direction register sets each pin input or output.
// - Input data register returns sampled level of input pins.
// - Output data register holds level driven on output pins.
// - Debounce register enables per-pin input debouncing.
// - Global control enables or disables all general-purpose pins.
// - Write-only set and clear registers affect only selected pins.
// - Pull registers set pull-up or pull-down; open-drain enabled per pin.
// - Alternative pins ignore general-purpose controls; use separate settings.
// - Separate rise and fall detect enables per line.
// - Masked lines record no event and assert no interrupt.
// ----------------------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none

module pgp_port (
  // Clock and reset
  input  wire        i_ref_clk,
  input  wire        i_reset,
  // General-purpose configuration
  input  wire [13:0] i_pad_function_select_a,
  input  wire [6:0]  i_pad_function_select_b,
  input  wire [6:0]  i_port_direction,
  input  wire [6:0]  i_port_debounce_enable,
  input  wire        i_port_global_enable,
  input  wire [7:0]  i_port_pull_config_a,
  input  wire [5:0]  i_port_pull_config_b,
  input  wire [6:0]  i_port_open_drain_enable,
  // Output data register access and input data readback
  input  wire        i_data_out_we,
  input  wire [6:0]  i_data_out_wdata,
  input  wire        i_set_we,
  input  wire [6:0]  i_set_mask,
  input  wire        i_clear_we,
  input  wire [6:0]  i_clear_mask,
  output wire [6:0]  o_data_out,
  output wire [6:0]  o_data_in,
  // Pin interrupt group
  input  wire [6:0]  i_pin_irq_rise_enable,
  input  wire [6:0]  i_pin_irq_fall_enable,
  input  wire [6:0]  i_pin_irq_mask,
  input  wire [6:0]  i_pin_irq_clear,
  output wire [6:0]  o_pin_irq_status,
  output wire        o_pin_irq,
  // Power state and wake
  input  wire        i_off_mode,
  output wire        o_wake_event,
  // Alternative function settings and sources
  input  wire [13:0] i_alt_pull_config,
  input  wire [6:0]  i_alt_open_drain_enable,
  input  wire [2:0]  i_seq_regen_step,
  input  wire        i_supplies_valid,
  input  wire        i_serial_data_out,
  input  wire        i_serial_data_oe,
  input  wire        i_serial_clk_cs_out,
  input  wire        i_serial_clk_cs_oe,
  // Alternative function inputs to the rest of the device
  output wire        o_power_down_in,
  output wire        o_periph_power_req_a,
  output wire        o_periph_power_req_b,
  output wire        o_reset_in,
  output wire        o_warm_reset_in_n,
  output wire        o_bus_voltage_detect,
  output wire        o_second_serial_data,
  output wire        o_second_serial_clk_cs,
  output wire        o_switcher_sync_in,
  output wire        o_power_hold_in,
  output wire        o_sleep_request_n,
  // Pads
  input  wire [6:0]  i_pad,
  output reg  [6:0]  o_pad,
  output reg  [6:0]  o_pad_oe,
  output reg  [13:0] o_pad_pull
);

`include "pgp_defines.vh"

  localparam integer DB_CYC_FULL = `PGP_DEBOUNCE_CYC;
  localparam [7:0]   DB_CYC      = DB_CYC_FULL[7:0];

  reg  [6:0]  data_out_q;
  reg  [6:0]  level_q;
  reg  [6:0]  status_q;
  reg  [6:0]  data_in_q;
  reg         wake_q;
  reg  [7:0]  div_q;
  reg         tick_q;
  reg  [6:0]  regen_q;
  wire [6:0]  level;
  wire [6:0]  gp_sel;
  wire [6:0]  gp_act;
  wire [6:0]  rise;
  wire [6:0]  fall;
  wire [6:0]  evt;
  wire [13:0] gp_pull;

  // ----------------------------------------------------------------------------
  // Pad function select: alt code zero means general-purpose
  // ----------------------------------------------------------------------------
  // Alt code per pin: select_a gives two bits, select_b the third
  wire [2:0] alt0 = {i_pad_function_select_b[0], i_pad_function_select_a[1:0]};
  wire [2:0] alt1 = {i_pad_function_select_b[1], i_pad_function_select_a[3:2]};
  wire [2:0] alt2 = {i_pad_function_select_b[2], i_pad_function_select_a[5:4]};
  wire [2:0] alt3 = {i_pad_function_select_b[3], i_pad_function_select_a[7:6]};
  wire [2:0] alt4 = {i_pad_function_select_b[4], i_pad_function_select_a[9:8]};
  wire [2:0] alt5 = {i_pad_function_select_b[5], i_pad_function_select_a[11:10]};
  wire [2:0] alt6 = {i_pad_function_select_b[6], i_pad_function_select_a[13:12]};

  assign gp_sel = {alt6 == `PGP_ALT_0, alt5 == `PGP_ALT_0, alt4 == `PGP_ALT_0,
                   alt3 == `PGP_ALT_0, alt2 == `PGP_ALT_0, alt1 == `PGP_ALT_0,
                   alt0 == `PGP_ALT_0};
  assign gp_act  = gp_sel & {7{i_port_global_enable}};
  assign gp_pull = {i_port_pull_config_b, i_port_pull_config_a};

  // ----------------------------------------------------------------------------
  // Debounce tick divider
  // ----------------------------------------------------------------------------
  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      div_q  <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (div_q == DB_CYC - 8'h01);
      if (div_q == DB_CYC - 8'h01) begin
        div_q <= 8'h00;
      end else begin
        div_q <= div_q + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Per-pin input path
  // ----------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `PGP_NPINS; g = g + 1) begin : g_pin
      pgp_debounce u_db (
        .i_ref_clk (i_ref_clk),
        .i_reset   (i_reset),
        .i_tick    (tick_q),
        .i_enable  (i_port_debounce_enable[g] & gp_sel[g]),
        .i_pin     (i_pad[g]),
        .o_level   (level[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // Edge detect, status, wake
  // ----------------------------------------------------------------------------
  assign rise = level & ~level_q & i_pin_irq_rise_enable;
  assign fall = ~level & level_q & i_pin_irq_fall_enable;
  // Masked or alternative lines see no event at all
  assign evt  = (rise | fall) & gp_act & ~i_pin_irq_mask & ~i_port_direction;

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      level_q   <= `PGP_RST_PINS;
      status_q  <= `PGP_RST_PINS;
      data_in_q <= `PGP_RST_PINS;
      wake_q    <= 1'b0;
    end else begin
      level_q   <= level;
      // New event wins over a clear in the same cycle
      status_q  <= (status_q & ~i_pin_irq_clear) | evt;
      data_in_q <= level & ~i_port_direction & gp_act;
      // I/O-domain pins cannot wake from OFF
      wake_q    <= |(evt & ~({7{i_off_mode}} & `PGP_IO_DOMAIN_MASK));
    end
  end

  assign o_pin_irq_status = status_q;
  assign o_pin_irq        = |status_q;
  assign o_wake_event     = wake_q;
  assign o_data_in        = data_in_q;
  assign o_data_out       = data_out_q;

  // ----------------------------------------------------------------------------
  // Output data register
  // ----------------------------------------------------------------------------
  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      data_out_q <= `PGP_RST_PINS;
    end else begin
      if (i_data_out_we) begin
        data_out_q <= i_data_out_wdata;
      end else begin
        data_out_q <= (data_out_q | ({7{i_set_we}} & i_set_mask))
                      & ~({7{i_clear_we}} & i_clear_mask);
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Regulator enables as sequencer steps
  // ----------------------------------------------------------------------------
  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      regen_q <= `PGP_RST_PINS;
    end else begin
      regen_q <= {i_seq_regen_step[2], i_seq_regen_step[2], i_seq_regen_step[1],
                  i_seq_regen_step[0], 2'b00, i_seq_regen_step[0]};
    end
  end

  // ----------------------------------------------------------------------------
  // Alternative input routing (synchronised level, no debounce)
  // ----------------------------------------------------------------------------
  assign o_power_down_in        = (alt0 == `PGP_ALT_1) & level[0];
  assign o_periph_power_req_b   = ((alt0 == `PGP_ALT_2) & level[0])
                                | ((alt2 == `PGP_ALT_2) & level[2]);
  assign o_reset_in             = (alt1 == `PGP_ALT_1) & level[1];
  assign o_warm_reset_in_n      = ~((alt1 == `PGP_ALT_2) & ~level[1]);
  assign o_bus_voltage_detect   = (alt1 == `PGP_ALT_3) & level[1];
  assign o_periph_power_req_a   = (alt1 == 3'h4) & level[1];
  assign o_second_serial_data   = (alt2 == `PGP_ALT_1) & level[2];
  assign o_switcher_sync_in     = (alt3 == `PGP_ALT_2) & level[3];
  assign o_second_serial_clk_cs = (alt4 == `PGP_ALT_2) & level[4];
  assign o_power_hold_in        = (alt5 == `PGP_ALT_1) & level[5];
  assign o_sleep_request_n      = ~((alt6 == `PGP_ALT_1) & ~level[6]);

  // ----------------------------------------------------------------------------
  // Pad drive
  // ----------------------------------------------------------------------------
  reg [6:0] alt_val;
  reg [6:0] alt_oe;
  reg [6:0] drv;
  reg [6:0] den;
  integer   k;
  integer   n;

  always @* begin
    alt_val = 7'h00;
    alt_oe  = 7'h00;
    alt_val[0] = regen_q[0];
    alt_oe[0]  = (alt0 == `PGP_ALT_3);
    alt_val[2] = i_serial_data_out;
    alt_oe[2]  = (alt2 == `PGP_ALT_1) & i_serial_data_oe;
    alt_val[3] = regen_q[3];
    alt_oe[3]  = (alt3 == `PGP_ALT_1);
    alt_val[4] = (alt4 == `PGP_ALT_1) ? regen_q[4] : i_serial_clk_cs_out;
    alt_oe[4]  = (alt4 == `PGP_ALT_1) | ((alt4 == `PGP_ALT_2) & i_serial_clk_cs_oe);
    alt_val[5] = regen_q[5];
    alt_oe[5]  = (alt5 == `PGP_ALT_2);
    alt_val[6] = (alt6 == `PGP_ALT_2) ? i_supplies_valid : regen_q[6];
    alt_oe[6]  = (alt6 == `PGP_ALT_2) | (alt6 == `PGP_ALT_3);
    for (k = 0; k < `PGP_NPINS; k = k + 1) begin
      drv[k] = gp_sel[k] ? data_out_q[k] : alt_val[k];
      den[k] = gp_sel[k] ? (gp_act[k] & i_port_direction[k]) : alt_oe[k];
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_pad      <= `PGP_RST_PINS;
      o_pad_oe   <= `PGP_RST_PINS;
      o_pad_pull <= 14'h0000;
    end else begin
      for (n = 0; n < `PGP_NPINS; n = n + 1) begin
        // Open drain: drive 0 only, release for 1
        if (gp_sel[n] ? i_port_open_drain_enable[n] : i_alt_open_drain_enable[n]) begin
          o_pad[n]    <= 1'b0;
          o_pad_oe[n] <= den[n] & ~drv[n];
        end else begin
          o_pad[n]    <= drv[n];
          o_pad_oe[n] <= den[n];
        end
      end
      // Each line keeps its own pull, whatever the others hold
      o_pad_pull <= pull_mux(gp_sel, gp_pull, i_alt_pull_config);
    end
  end

  function [13:0] pull_mux;
    input [6:0]  sel;
    input [13:0] gp;
    input [13:0] alt;
    integer      j;
    begin
      for (j = 0; j < 7; j = j + 1) begin
        pull_mux[2*j +: 2] = sel[j] ? gp[2*j +: 2] : alt[2*j +: 2];
      end
    end
  endfunction

endmodule // pgp_port

`default_nettype wire

// *** design/pgp_defines.vh ***
// Constants for the multiplexed general-purpose pin port
`ifndef PGP_DEFINES_VH
`define PGP_DEFINES_VH

// ----------------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------------
`define PGP_NPINS         7
`define PGP_W             8

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define PGP_RST_BYTE      8'h00
`define PGP_RST_PINS      7'h00

// ----------------------------------------------------------------------------
// Pull encoding (two bits per pin)
// ----------------------------------------------------------------------------
`define PGP_PULL_NONE     2'h0
`define PGP_PULL_DOWN     2'h1
`define PGP_PULL_UP       2'h2

// ----------------------------------------------------------------------------
// Alternative function codes per pin (three bits per pin)
// ----------------------------------------------------------------------------
`define PGP_ALT_W         3
`define PGP_ALT_0         3'h0
`define PGP_ALT_1         3'h1
`define PGP_ALT_2         3'h2
`define PGP_ALT_3         3'h3

// ----------------------------------------------------------------------------
// Pins in the I/O supply domain (pins 2 and 4)
// ----------------------------------------------------------------------------
`define PGP_IO_DOMAIN_MASK 7'h14

// ----------------------------------------------------------------------------
// Debounce timing
// ----------------------------------------------------------------------------
`define PGP_CLK_MHZ       250
`define PGP_DEBOUNCE_US   1
`define PGP_DEBOUNCE_CYC  (`PGP_DEBOUNCE_US * `PGP_CLK_MHZ)

`endif

// *** design/pgp_debounce.v ***
// Per-pin synchroniser and optional debounce filter
`timescale 1ns/100ps
`default_nettype none

module pgp_debounce (
  // Clock and reset
  input  wire       i_ref_clk,
  input  wire       i_reset,
  // Control
  input  wire       i_tick,
  input  wire       i_enable,
  // Pin
  input  wire       i_pin,
  output wire       o_level
);

`include "pgp_defines.vh"

  reg        sync1_q;
  reg        sync2_q;
  reg        stable_q;
  reg  [1:0] cnt_q;

  assign o_level = i_enable ? stable_q : sync2_q;

  // ----------------------------------------------------------------------------
  // Sync and filter
  // ----------------------------------------------------------------------------
  always @(posedge i_ref_clk) begin
    if (i_reset) begin
      sync1_q  <= 1'b0;
      sync2_q  <= 1'b0;
      stable_q <= 1'b0;
      cnt_q    <= 2'h0;
    end else begin
      sync1_q <= i_pin;
      sync2_q <= sync1_q;
      // Level must hold over four ticks before it is accepted
      if (sync2_q == stable_q) begin
        cnt_q <= 2'h0;
      end else if (i_tick) begin
        if (cnt_q == 2'h3) begin
          stable_q <= sync2_q;
          cnt_q    <= 2'h0;
        end else begin
          cnt_q <= cnt_q + 2'h1;
        end
      end
    end
  end

endmodule // pgp_debounce

`default_nettype wire

// *** verif/pgp_port_properties.sv ***
// Concurrent checks on the pin port
`timescale 1ns/100ps
`default_nettype none
module pgp_port_properties (
  // Clock and reset
  input wire logic        i_ref_clk,
  input wire logic        i_reset,
  // Configuration and requests
  input wire logic [13:0] i_pad_function_select_a,
  input wire logic [6:0]  i_pad_function_select_b,
  input wire logic [6:0]  i_port_direction,
  input wire logic        i_port_global_enable,
  input wire logic [6:0]  i_port_open_drain_enable,
  input wire logic        i_data_out_we,
  input wire logic [6:0]  i_data_out_wdata,
  input wire logic        i_set_we,
  input wire logic [6:0]  i_set_mask,
  input wire logic        i_clear_we,
  input wire logic [6:0]  i_clear_mask,
  input wire logic [6:0]  i_pin_irq_mask,
  input wire logic [6:0]  i_pin_irq_clear,
  input wire logic        i_off_mode,
  // Outputs
  input wire logic [6:0]  o_data_out,
  input wire logic [6:0]  o_pin_irq_status,
  input wire logic        o_pin_irq,
  input wire logic        o_wake_event,
  input wire logic        o_warm_reset_in_n,
  input wire logic [6:0]  o_pad,
  input wire logic [6:0]  o_pad_oe
);
  // ------------
  // Helpers
  // ------------
  logic [6:0] gp;
  logic [6:0] pp;
  logic [6:0] od;
  always_comb begin
    for (int k = 0; k < 7; k++) begin
      gp[k] = ({i_pad_function_select_b[k], i_pad_function_select_a[2*k +: 2]} == 3'h0);
    end
    pp = gp & i_port_direction & {7{i_port_global_enable}} & ~i_port_open_drain_enable;
    od = gp & i_port_direction & {7{i_port_global_enable}} & i_port_open_drain_enable;
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  // Pads lag config by a cycle, so only judge steady settings
  sequence s_steady(m);
    (m != 7'h00) ##1 ($stable(m) && $stable(o_data_out));
  endsequence
  sequence s_write;
    i_data_out_we;
  endsequence
  sequence s_not_warm;
    ({i_pad_function_select_b[1], i_pad_function_select_a[3:2]} != 3'h2) [*2];
  endsequence
  // ------------
  // Assertions
  // ------------
  a_irq_line_or: assert property (o_pin_irq == |o_pin_irq_status)
    else $error("irq line differs from status");
  a_status_sticky: assert property (
    ($past(o_pin_irq_status) & ~$past(i_pin_irq_clear) & ~o_pin_irq_status) == 7'h00)
    else $error("status bit dropped without clear");
  a_masked_no_new: assert property (
    (o_pin_irq_status & ~$past(o_pin_irq_status) & ($past(i_pin_irq_mask) | ~$past(gp))) == 7'h00)
    else $error("status set on masked or alternate pin");
  a_new_wake: assert property (
    |(o_pin_irq_status & ~$past(o_pin_irq_status) & ~({7{$past(i_off_mode)}} & 7'h14))
    |-> o_wake_event)
    else $error("event without wake");
  a_plain_write: assert property (s_write |=> o_data_out == $past(i_data_out_wdata))
    else $error("data out not written");
  a_set_clear: assert property (!$past(i_data_out_we) |-> o_data_out ==
    (($past(o_data_out) | ($past(i_set_we) ? $past(i_set_mask) : 7'h00))
     & ~($past(i_clear_we) ? $past(i_clear_mask) : 7'h00)))
    else $error("set or clear wrong");
  a_gp_drive: assert property (s_steady(pp) |-> ((o_pad_oe & pp) == pp)
    && ((o_pad & pp) == (o_data_out & pp)))
    else $error("push-pull pad wrong");
  a_open_drain: assert property (s_steady(od) |-> ((o_pad_oe & od) == (~o_data_out & od))
    && ((o_pad & o_pad_oe & od) == 7'h00))
    else $error("open-drain pad wrong");
  a_warm_idle: assert property (s_not_warm |-> o_warm_reset_in_n)
    else $error("warm reset active while unselected");
endmodule // pgp_port_properties
bind pgp_port pgp_port_properties u_pgp_port_properties (
  .i_ref_clk, .i_reset, .i_pad_function_select_a, .i_pad_function_select_b,
  .i_port_direction, .i_port_global_enable, .i_port_open_drain_enable, .i_data_out_we,
  .i_data_out_wdata, .i_set_we, .i_set_mask, .i_clear_we, .i_clear_mask, .i_pin_irq_mask,
  .i_pin_irq_clear, .i_off_mode, .o_data_out, .o_pin_irq_status, .o_pin_irq, .o_wake_event,
  .o_warm_reset_in_n, .o_pad, .o_pad_oe
);
`default_nettype wire

// *** verif/pgp_board.sv ***
// Board-side model of the pad wiring
`timescale 1ns/100ps
`default_nettype none
module pgp_board (
  // Clock
  input  wire logic        i_ref_clk,
  // Port pad drive
  input  wire logic [6:0]  i_pad_out,
  input  wire logic [6:0]  i_pad_oe,
  input  wire logic [13:0] i_pad_pull,
  // External drivers
  input  wire logic [6:0]  i_ext_val,
  input  wire logic [6:0]  i_ext_en,
  // Resolved level
  output var  logic [6:0]  o_line
);
  // Floating lines wander so a stale level never looks valid
  logic [6:0] float_q = 7'h00;
  always @(posedge i_ref_clk) begin
    float_q <= ~float_q;
  end
  always_comb begin
    for (int k = 0; k < 7; k++) begin
      if (i_pad_oe[k]) begin
        o_line[k] = i_pad_out[k];
      end else if (i_ext_en[k]) begin
        o_line[k] = i_ext_val[k];
      end else if (i_pad_pull[2*k +: 2] == 2'h2) begin
        o_line[k] = 1'b1;
      end else if (i_pad_pull[2*k +: 2] == 2'h1) begin
        o_line[k] = 1'b0;
      end else begin
        o_line[k] = float_q[k];
      end
    end
  end
endmodule // pgp_board
`default_nettype wire

// *** verif/pgp_port_tb.sv ***
// Self-checking testbench of the pin port
`timescale 1ns/100ps
`default_nettype none
module pgp_port_tb;
  logic        clk, rst, glob, we, set_we, clr_we, off, sup;
  logic [13:0] sel_a, alt_pull, pad_pull;
  logic [7:0]  pull_a;
  logic [5:0]  pull_b;
  logic [6:0]  sel_b, dir, deb, od, wd, sm, cm, rise, fall, mask, clr, ext_val, ext_en;
  logic [6:0]  dout, din, stat, pad, pad_oe, line, mdl, ev;
  logic [2:0]  step;
  logic        irq, wake, pdown, warm_n, sleep_n;
  logic [7:0]  alt_in;
  logic [6:0]  alt_od;
  logic [1:0]  ser;
  int          miscompares, check_count, wake_cnt;

  pgp_port u_pgp_port (
    .i_ref_clk(clk), .i_reset(rst), .i_pad_function_select_a(sel_a),
    .i_pad_function_select_b(sel_b), .i_port_direction(dir), .i_port_debounce_enable(deb),
    .i_port_global_enable(glob), .i_port_pull_config_a(pull_a), .i_port_pull_config_b(pull_b),
    .i_port_open_drain_enable(od), .i_data_out_we(we), .i_data_out_wdata(wd),
    .i_set_we(set_we), .i_set_mask(sm), .i_clear_we(clr_we), .i_clear_mask(cm),
    .o_data_out(dout), .o_data_in(din), .i_pin_irq_rise_enable(rise),
    .i_pin_irq_fall_enable(fall), .i_pin_irq_mask(mask), .i_pin_irq_clear(clr),
    .o_pin_irq_status(stat), .o_pin_irq(irq), .i_off_mode(off), .o_wake_event(wake),
    .i_alt_pull_config(alt_pull), .i_alt_open_drain_enable(alt_od), .i_seq_regen_step(step),
    .i_supplies_valid(sup), .i_serial_data_out(ser[0]), .i_serial_data_oe(ser[1]),
    .i_serial_clk_cs_out(1'b0), .i_serial_clk_cs_oe(1'b0), .o_power_down_in(pdown),
    .o_periph_power_req_a(alt_in[0]), .o_periph_power_req_b(alt_in[1]),
    .o_reset_in(alt_in[2]), .o_warm_reset_in_n(warm_n), .o_bus_voltage_detect(alt_in[3]),
    .o_second_serial_data(alt_in[4]), .o_second_serial_clk_cs(alt_in[5]),
    .o_switcher_sync_in(alt_in[6]), .o_power_hold_in(alt_in[7]),
    .o_sleep_request_n(sleep_n), .i_pad(line), .o_pad(pad), .o_pad_oe(pad_oe),
    .o_pad_pull(pad_pull)
  );
  pgp_board u_pgp_board (
    .i_ref_clk(clk), .i_pad_out(pad), .i_pad_oe(pad_oe), .i_pad_pull(pad_pull),
    .i_ext_val(ext_val), .i_ext_en(ext_en), .o_line(line)
  );

  // ------------
  // Helpers
  // ------------
  always #2 clk = ~clk;
  always @(posedge clk) begin
    if (wake === 1'b1) wake_cnt++;
  end
  task automatic check(input string nm, input logic [13:0] seen, input logic [13:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic clear_irq();
    clr = 7'h7F;
    cyc(1);
    clr = 7'h00;
  endtask
  // Full write beats set/clear; clear beats set
  function automatic logic [6:0] next_out(input logic [6:0] o, input logic w, s, c);
    return w ? wd : ((o | (s ? sm : 7'h00)) & ~(c ? cm : 7'h00));
  endfunction

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_of_test();
  end
  // ------------
  // Scenarios
  // ------------
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {glob, we, set_we, clr_we, off, sup, step} = '0;
    {sel_a, alt_pull, pull_a, pull_b, sel_b, dir, deb, od, wd, sm, cm} = '0;
    {rise, fall, mask, clr, ext_val, ext_en, mdl, alt_od, ser} = '0;
    {miscompares, check_count, wake_cnt} = '0;
    void'($urandom(32'hA77C));
    cyc(10);
    rst = 1'b0;
    cyc(1);
    check("data_out_rst", dout, 7'h00);
    check("status_rst", stat, 7'h00);
    check("alt_idle", {warm_n, sleep_n, pdown, alt_in}, 11'h600);
    for (int i = 0; i < 60; i++) begin
      we = ($urandom % 4) == 0;
      {set_we, clr_we, wd, sm, cm} = $urandom;
      if (i == 0) {we, set_we, clr_we, sm, cm} = {3'h3, 7'h7F, 7'h55};
      mdl = next_out(mdl, we, set_we, clr_we);
      cyc(1);
      check("data_out", dout, mdl);
    end
    {we, set_we, clr_we} = 3'h0;
    glob = 1'b1;
    dir = 7'h7F;
    cyc(3);
    check("pad_oe", pad_oe, 7'h7F);
    check("pad", pad, mdl);
    od = 7'h7F;
    {pull_b, pull_a} = 14'h2AAA;
    cyc(3);
    check("pad_oe_od", pad_oe, mdl ^ 7'h7F);
    check("line_od", line, mdl);
    check("pull", pad_pull, 14'h2AAA);
    glob = 1'b0;
    cyc(3);
    check("pad_oe_off", pad_oe, 7'h00);
    {glob, dir, od, ext_en} = {1'b1, 7'h00, 7'h00, 7'h7F};
    ext_val = $urandom;
    cyc(5);
    check("data_in", din, ext_val);
    ev = ext_val;
    deb = 7'h01;
    // Let the filter settle on the present level first
    cyc(1100);
    check("debounce_settle", din[0], ev[0]);
    ext_val[0] = ~ev[0];
    cyc(5);
    check("debounce_hold", din[0], ev[0]);
    cyc(1300);
    check("debounce_pass", din[0], !ev[0]);
    deb = 7'h00;
    for (int k = 0; k < 7; k++) begin
      for (int m = 1; m < 4; m++) begin
        rise = m[0] ? 7'h7F : 7'h00;
        fall = m[1] ? 7'h7F : 7'h00;
        ext_val[k] = 1'b0;
        cyc(6);
        clear_irq();
        ext_val[k] = 1'b1;
        cyc(6);
        check("irq_rise", stat, m[0] << k);
        check("irq_line", irq, m[0]);
        clear_irq();
        ext_val[k] = 1'b0;
        cyc(6);
        check("irq_fall", stat, m[1] << k);
      end
    end
    clear_irq();
    mask = 7'h7F;
    ext_val[1] = 1'b1;
    cyc(6);
    check("irq_masked", stat, 7'h00);
    {mask, alt_pull, sel_a} = {7'h00, 14'h0001, 14'h0009};
    cyc(6);
    ext_val[0] = 1'b1;
    ext_val[1] = 1'b0;
    cyc(6);
    check("irq_alt", stat, 7'h00);
    check("power_down", pdown, 1'b1);
    check("warm_reset", warm_n, 1'b0);
    check("alt_pull", pad_pull[1:0], 2'h1);
    {sel_a, step, sup} = {14'h2040, 3'h1, 1'b1};
    cyc(4);
    check("regen_oe", pad_oe & 7'h48, 7'h48);
    check("regen_on", pad & 7'h48, 7'h48);
    {step, sup} = 4'h0;
    cyc(4);
    check("regen_off", pad & 7'h48, 7'h00);
    {step, alt_od} = {3'h1, 7'h08};
    cyc(4);
    check("alt_od", pad_oe & 7'h48, 7'h40);
    {sel_a, sel_b, step, alt_od, ext_val} = {14'h1692, 7'h02, 3'h0, 7'h00, 7'h3F};
    cyc(6);
    check("alt_inputs", alt_in, 8'hF3);
    check("alt_sleep", {sleep_n, pdown, stat}, 9'h000);
    ser = 2'h2;
    cyc(4);
    check("serial_drive", {pad_oe[2], pad[2], alt_in[4]}, 3'h4);
    {sel_a, sel_b, ser} = {14'h0004, 7'h00, 2'h0};
    cyc(4);
    check("reset_in", alt_in, 8'h04);
    sel_a = 14'h000C;
    cyc(4);
    check("bus_sense", alt_in, 8'h08);
    {sel_a, rise, fall, off, ext_val} = {14'h0000, 7'h7F, 7'h00, 1'b1, 7'h00};
    cyc(6);
    clear_irq();
    wake_cnt = 0;
    ext_val = 7'h14;
    cyc(6);
    check("wake_io_off", wake_cnt, 0);
    check("status_io", stat, 7'h14);
    ext_val[0] = 1'b1;
    cyc(6);
    check("wake_pin0", wake_cnt, 1);
    end_of_test();
  end
endmodule // pgp_port_tb
`default_nettype wire
